// *** rtl/timer_control.sv ***
// Control, mode and command logic of the 16-bit timer with its APB register file
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_control
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [`APB_ADDR_WIDTH-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Power state
   input wire logic STANDBY_SLEEP,
   // Counter status and buffer writes
   input wire logic COUNT_AT_TOP,
   input wire logic COUNT_AT_BOTTOM,
   input wire logic LENGTH_BUFFER_WRITE,
   input wire logic [2:0] COMPARE_BUFFER_WRITE,
   // Direction from event actions
   input wire logic EVENT_DIR_LOAD,
   input wire logic EVENT_DIR,
   // Waveform generator value while running
   input wire logic [2:0] WAVE_GEN,
   // Counter control
   output logic COUNT_RUN,
   output logic COUNT_TICK,
   output logic COUNT_DOWN,
   output logic TOP_FROM_COMPARE0,
   output logic SPLIT_MODE,
   output logic UPDATE_LOAD,
   output logic RESTART_PULSE,
   output logic HARD_RESET_PULSE,
   output logic OVERFLOW_PULSE,
   output logic LOCK_UPDATE,
   // Waveform outputs
   output logic [2:0] WAVE_PIN,
   output logic [2:0] WAVE_PIN_OE,
   output logic [2:0] WAVE_LOGIC
);
   control_state_type s;
   control_state_type n;
   prescale_if pre ();

   logic setup;
   logic write;
   logic hit;
   logic [2:0] index;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [1:0] command;
   logic hw_update;
   logic hw_overflow;
   logic cmd_update;
   logic load;
   logic all_valid;
   logic dual_slope;
   logic waveform_mode_on;

   // Divider producing the counting rate
   clock_divider divider (
      .clk(REF_CLK),
      .nrst(NRST),
      .pre(pre)
   );

   // Divider runs only while enabled and not halted by standby
   assign pre.run = s.count_run;
   assign pre.select = s.prescaler_select;
   assign pre.clear = s.restart | s.hard_reset;

   // Address decode: word aligned, index in bits 4:2, upper bits zero
   always_comb begin
      index = PADDR[4:2];
      hit = (PADDR[1:0] == 2'h0) && (PADDR[`APB_ADDR_WIDTH-1:5] == '0);
      setup = PSEL && !PENABLE;
      write = PSEL && PENABLE && PWRITE && s.pready && hit;
      wdata = PWDATA[7:0];
   end

   // Read mux; set and clear views show the shared bits
   always_comb begin
      rdata = `RESET_BYTE;
      case (index)
         `IDX_CONTROL_A: begin
            rdata = {s.run_in_standby, 3'h0, s.prescaler_select, s.enable};
         end
         `IDX_CONTROL_B: begin
            rdata = {1'b0, s.compare_output_enable, s.auto_lock_update, s.waveform_mode};
         end
         `IDX_OUTPUT_VALUE: begin
            rdata = {5'h00, s.compare_output_value};
         end
         `IDX_SPLIT: begin
            rdata = {7'h00, s.split_mode_enable};
         end
         `IDX_CONTROL_E_CLEAR, `IDX_CONTROL_E_SET: begin
            rdata = {4'h0, `CMD_NONE, s.lock_update, s.count_down}; // [RQ16] [RQ24]
         end
         default: begin
            rdata = {4'h0, s.compare_buffer_valid, s.length_buffer_valid}; // [RQ24]
         end
      endcase
   end

   // Update and overflow moments per waveform mode
   always_comb begin
      hw_update = 1'b0;
      hw_overflow = 1'b0;
      dual_slope = 1'b0;
      waveform_mode_on = 1'b0;
      case (s.waveform_mode)
         `MODE_NORMAL: begin
            hw_update = COUNT_AT_TOP && !s.count_down; // [RQ7]
            hw_overflow = COUNT_AT_TOP && !s.count_down;
         end
         `MODE_FREQUENCY: begin
            hw_update = COUNT_AT_TOP && !s.count_down; // [RQ7]
            hw_overflow = COUNT_AT_TOP && !s.count_down;
            waveform_mode_on = 1'b1;
         end
         `MODE_SINGLE_SLOPE: begin
            hw_update = COUNT_AT_BOTTOM; // [RQ8]
            hw_overflow = COUNT_AT_BOTTOM;
            waveform_mode_on = 1'b1;
         end
         `MODE_DUAL_TOP: begin
            hw_update = COUNT_AT_BOTTOM; // [RQ8]
            hw_overflow = COUNT_AT_TOP;
            dual_slope = 1'b1;
            waveform_mode_on = 1'b1;
         end
         `MODE_DUAL_BOTH: begin
            hw_update = COUNT_AT_BOTTOM; // [RQ8]
            hw_overflow = COUNT_AT_TOP || COUNT_AT_BOTTOM;
            dual_slope = 1'b1;
            waveform_mode_on = 1'b1;
         end
         `MODE_DUAL_BOTTOM: begin
            hw_update = COUNT_AT_BOTTOM; // [RQ8]
            hw_overflow = COUNT_AT_BOTTOM;
            dual_slope = 1'b1;
            waveform_mode_on = 1'b1;
         end
         default: begin
            // Reserved codes: no update, no overflow, no waveform
            hw_update = 1'b0; // [RQ8]
         end
      endcase
   end

   // Command written through either control E view
   always_comb begin
      command = `CMD_NONE;
      if (write && (index == `IDX_CONTROL_E_CLEAR || index == `IDX_CONTROL_E_SET)) begin
         command = wdata[3:2];
      end
      cmd_update = (command == `CMD_UPDATE); // [RQ16]
      load = (hw_update && !s.lock_update) || cmd_update; // [RQ18] [RQ19]
      all_valid = &(s.compare_buffer_valid | ~s.compare_output_enable);
   end

   // Next state
   always_comb begin
      n = s;
      // APB: answer ready one cycle after setup, then drop it
      n.pready = setup;
      n.pslverr = setup && !hit;
      n.prdata = (setup && hit && !PWRITE) ? {24'h000000, rdata} : 32'h00000000;
      // Plain read-write registers
      if (write && index == `IDX_CONTROL_A) begin
         n.run_in_standby = wdata[`BIT_RUN_IN_STANDBY]; // [RQ1]
         n.prescaler_select = wdata[3:1]; // [RQ2]
         n.enable = wdata[`BIT_ENABLE]; // [RQ3]
      end
      if (write && index == `IDX_CONTROL_B) begin
         n.compare_output_enable = wdata[6:4];
         n.auto_lock_update = wdata[`BIT_AUTO_LOCK];
         n.waveform_mode = wdata[2:0];
      end
      if (write && index == `IDX_OUTPUT_VALUE) begin
         n.compare_output_value = wdata[2:0];
      end
      if (write && index == `IDX_SPLIT) begin
         n.split_mode_enable = wdata[0]; // [RQ13]
      end
      // Direction: hardware turn points, then events, then software
      if (dual_slope && COUNT_AT_TOP) begin
         n.count_down = 1'b1; // [RQ21]
      end else if (dual_slope && COUNT_AT_BOTTOM) begin
         n.count_down = 1'b0; // [RQ21]
      end
      if (EVENT_DIR_LOAD) begin
         n.count_down = EVENT_DIR; // [RQ21]
      end
      // Control E clear and set views
      if (write && index == `IDX_CONTROL_E_CLEAR) begin
         n.lock_update = s.lock_update & ~wdata[`BIT_LOCK]; // [RQ14]
         n.count_down = n.count_down & ~wdata[`BIT_DIR]; // [RQ14] [RQ21]
      end
      if (write && index == `IDX_CONTROL_E_SET) begin
         n.lock_update = s.lock_update | wdata[`BIT_LOCK]; // [RQ15]
         n.count_down = n.count_down | wdata[`BIT_DIR]; // [RQ15] [RQ21]
      end
      // Auto-lock: lock on enabling, release when all enabled compare buffers valid, relock on load
      if (write && index == `IDX_CONTROL_B && wdata[`BIT_AUTO_LOCK] && !s.auto_lock_update) begin
         n.lock_update = 1'b1; // [RQ5]
      end else if (s.auto_lock_update) begin
         if (load) begin
            n.lock_update = 1'b1; // [RQ6]
         end else if (s.lock_update && all_valid) begin
            n.lock_update = 1'b0; // [RQ5]
         end
      end
      // Buffer-valid flags: a load clears, writes set, and a set wins
      if (load) begin
         n.compare_buffer_valid = 3'h0; // [RQ22]
         n.length_buffer_valid = 1'b0; // [RQ23]
      end
      if (write && index == `IDX_BUFFER_VALID_CLEAR) begin
         n.compare_buffer_valid = n.compare_buffer_valid & ~wdata[3:1]; // [RQ14]
         n.length_buffer_valid = n.length_buffer_valid & ~wdata[0]; // [RQ14]
      end
      if (write && index == `IDX_BUFFER_VALID_SET) begin
         n.compare_buffer_valid = n.compare_buffer_valid | wdata[3:1]; // [RQ15]
         n.length_buffer_valid = n.length_buffer_valid | wdata[0]; // [RQ15]
      end
      n.compare_buffer_valid = n.compare_buffer_valid | COMPARE_BUFFER_WRITE; // [RQ22]
      n.length_buffer_valid = n.length_buffer_valid | LENGTH_BUFFER_WRITE; // [RQ23]
      // Waveform value: generator while running, direct value while stopped
      if (s.enable) begin
         n.wave_value = WAVE_GEN;
      end else if (write && index == `IDX_OUTPUT_VALUE) begin
         n.wave_value = wdata[2:0]; // [RQ11]
      end
      // Pad drive only in waveform modes with the channel enabled
      // Mode and enables come from the same registered copy, so a stale pairing never drives a pad
      n.pin_oe = waveform_mode_on ? s.compare_output_enable : 3'h0; // [RQ4] [RQ9] [RQ12]
      n.top_from_compare0 = (n.waveform_mode == `MODE_FREQUENCY); // [RQ7]
      // Counting runs when enabled, unless standby halts it
      n.count_run = n.enable && (!STANDBY_SLEEP || n.run_in_standby); // [RQ1] [RQ3]
      n.count_tick = pre.tick && s.count_run;
      // Event pulses
      n.update_load = load; // [RQ18] [RQ19]
      n.overflow = hw_overflow;
      n.restart = (command == `CMD_RESTART); // [RQ16]
      n.hard_reset = (command == `CMD_RESET) && !s.enable; // [RQ17]
      // Hard reset returns the timer state to reset values; control is kept
      if (n.hard_reset) begin
         n.lock_update = 1'b0; // [RQ17]
         n.count_down = 1'b0;
         n.compare_buffer_valid = 3'h0;
         n.length_buffer_valid = 1'b0;
         n.wave_value = 3'h0;
      end
   end

   // State register
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Outputs come straight from the state flops
   assign PRDATA = s.prdata;
   assign PREADY = s.pready;
   assign PSLVERR = s.pslverr;
   assign COUNT_RUN = s.count_run;
   assign COUNT_TICK = s.count_tick;
   assign COUNT_DOWN = s.count_down; // [RQ20]
   assign TOP_FROM_COMPARE0 = s.top_from_compare0;
   assign SPLIT_MODE = s.split_mode_enable;
   assign UPDATE_LOAD = s.update_load;
   assign RESTART_PULSE = s.restart;
   assign HARD_RESET_PULSE = s.hard_reset;
   assign OVERFLOW_PULSE = s.overflow;
   assign LOCK_UPDATE = s.lock_update;
   // Pad path gated by enables; logic-block path bypasses them
   assign WAVE_PIN = s.wave_value; // [RQ12]
   assign WAVE_PIN_OE = s.pin_oe; // [RQ10]
   assign WAVE_LOGIC = s.wave_value; // [RQ12]
endmodule : timer_control

// *** rtl/timer_cfg.svh ***
// Offsets, field positions, codes and reset values of the timer control block
// What this block does
// [RQ1] Run-in-standby one keeps the timer running in standby; zero halts it there.
// [RQ2] Prescaler select codes 0..7 divide by 1, 2, 4, 8, 16, 64, 256, 1024.
// [RQ3] Control A bit zero enables the timer; zero keeps it disabled.
// [RQ4] In frequency and PWM modes an output enable routes the waveform to its pin.
// [RQ5] Auto-lock holds lock update high until all enabled compare buffers are valid.
// [RQ6] Under auto-lock, the next update loads the buffers and sets lock update again.
// [RQ7] Modes 0 and 1: TOP from period or compare 0, update and overflow at TOP. The code gives them at TOP only while counting up, none counting down.
// [RQ8] Mode 3 single slope; modes 5, 6, 7 dual slope; codes 2 and 4 reserved.
// [RQ9] Normal mode drives no waveform; otherwise a pin needs its output enable.
// [RQ10] Software must make the port pin an output to see the waveform.
// [RQ11] While disabled, output value writes set or clear the waveform outputs directly.
// [RQ12] Direct values reach a pad only when enabled; the logic-block path bypasses enables.
// [RQ13] Split-mode bit makes the unit two independent 8-bit timers.
// [RQ14] Writing one to a clear-type register clears that underlying bit.
// [RQ15] Writing one to a set-type register sets that underlying bit.
// [RQ16] Command 0 nothing, 1 forced update, 2 forced restart; reads as zero.
// [RQ17] Command 3 hard-resets the timer only while it is disabled.
// [RQ18] Lock update zero lets updates load buffers; one blocks them.
// [RQ19] A commanded update loads buffers even while lock update is one.
// [RQ20] Direction zero counts up, one counts down.
// [RQ21] Hardware and software may both drive the direction bit.
// [RQ22] A compare buffer-valid flag sets on buffer write, clears on update.
// [RQ23] The period buffer-valid flag sets on buffer write, clears on update.
// [RQ24] Set and clear registers read the shared bits; command reads zero.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define APB_ADDR_WIDTH 8
// Register indices; byte address is four times the index
`define IDX_CONTROL_A 3'h0
`define IDX_CONTROL_B 3'h1
`define IDX_OUTPUT_VALUE 3'h2
`define IDX_SPLIT 3'h3
`define IDX_CONTROL_E_CLEAR 3'h4
`define IDX_CONTROL_E_SET 3'h5
`define IDX_BUFFER_VALID_CLEAR 3'h6
`define IDX_BUFFER_VALID_SET 3'h7
`define RESET_BYTE 8'h00
// Field positions
`define BIT_ENABLE 0
`define BIT_RUN_IN_STANDBY 7
`define BIT_AUTO_LOCK 3
`define BIT_DIR 0
`define BIT_LOCK 1
// Command codes
`define CMD_NONE 2'h0
`define CMD_UPDATE 2'h1
`define CMD_RESTART 2'h2
`define CMD_RESET 2'h3
// Waveform mode codes
`define MODE_NORMAL 3'h0
`define MODE_FREQUENCY 3'h1
`define MODE_SINGLE_SLOPE 3'h3
`define MODE_DUAL_TOP 3'h5
`define MODE_DUAL_BOTH 3'h6
`define MODE_DUAL_BOTTOM 3'h7
// Prescaler masks: tick when the low counter bits are all ones
`define DIV1_MASK 10'h000
`define DIV2_MASK 10'h001
`define DIV4_MASK 10'h003
`define DIV8_MASK 10'h007
`define DIV16_MASK 10'h00F
`define DIV64_MASK 10'h03F
`define DIV256_MASK 10'h0FF
`define DIV1024_MASK 10'h3FF
`endif

// *** rtl/timer_pkg.sv ***
// Types shared by the timer control block
package timer_pkg;
   typedef logic [2:0] wave_mode_type;
   typedef struct packed {
      logic [9:0] count;
      logic tick;
   } prescale_state_type;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic run_in_standby;
      logic [2:0] prescaler_select;
      logic enable;
      logic [2:0] compare_output_enable;
      logic auto_lock_update;
      wave_mode_type waveform_mode;
      logic [2:0] compare_output_value;
      logic split_mode_enable;
      logic lock_update;
      logic count_down;
      logic [2:0] compare_buffer_valid;
      logic length_buffer_valid;
      logic [2:0] wave_value;
      logic [2:0] pin_oe;
      logic top_from_compare0;
      logic count_tick;
      logic count_run;
      logic update_load;
      logic restart;
      logic hard_reset;
      logic overflow;
   } control_state_type;
endpackage : timer_pkg

// *** rtl/prescale_if.sv ***
// Link between the timer control and its clock divider
`timescale 1ns/1ps
interface prescale_if;
   logic run;
   logic clear;
   logic [2:0] select;
   logic tick;
   modport control (output run, output clear, output select, input tick);
   modport divider (input run, input clear, input select, output tick);
endinterface : prescale_if

// *** rtl/clock_divider.sv ***
// Prescaler producing the counting tick from the peripheral clock
`timescale 1ns/1ps
`include "timer_cfg.svh"
module clock_divider
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control side
   prescale_if.divider pre
);
   prescale_state_type s;
   prescale_state_type n;
   logic [9:0] mask;

   // Select the division mask and advance the free count while running
   always_comb begin
      n = s;
      case (pre.select)
         3'h0: mask = `DIV1_MASK; // [RQ2]
         3'h1: mask = `DIV2_MASK;
         3'h2: mask = `DIV4_MASK;
         3'h3: mask = `DIV8_MASK;
         3'h4: mask = `DIV16_MASK;
         3'h5: mask = `DIV64_MASK;
         3'h6: mask = `DIV256_MASK;
         default: mask = `DIV1024_MASK;
      endcase
      if (pre.clear || !pre.run) begin
         // A halted divider restarts its phase so the first period is whole
         n.count = 10'h000;
         n.tick = 1'b0;
      end else begin
         n.count = s.count + 10'h001;
         n.tick = ((s.count & mask) == mask); // [RQ2]
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign pre.tick = s.tick;
endmodule : clock_divider

// *** tb/timer_control_sva.sv ***
// Port-level assertions for the timer control block
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_control_sva
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // Register bus
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [`APB_ADDR_WIDTH-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Timer outputs
   input wire logic COUNT_RUN,
   input wire logic COUNT_TICK,
   input wire logic COUNT_DOWN,
   input wire logic TOP_FROM_COMPARE0,
   input wire logic SPLIT_MODE,
   input wire logic HARD_RESET_PULSE,
   input wire logic LOCK_UPDATE
);
   logic wr_done;
   // A write lands at the edge where the access phase sees ready
   assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!NRST);
   // Bus answer and refusal
   ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup");
   unmapped_refused_a: assert property (PSEL && !PENABLE && (PADDR[1:0] != 2'h0 || PADDR[7:5] != 3'h0)
      |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
   command_reads_zero_a: assert property (PSEL && PENABLE && PREADY && !PWRITE && (PADDR == 8'h10 || PADDR == 8'h14)
      |-> PRDATA[3:2] == 2'h0) else $error("command field read nonzero");
   // Tick may trail the run flag by one cycle when the timer stops
   tick_needs_run_a: assert property (COUNT_TICK |-> COUNT_RUN || $past(COUNT_RUN))
      else $error("tick while stopped");
   // Control fields reach their outputs at the write edge
   split_follows_a: assert property (wr_done && PADDR == 8'h0C |=> SPLIT_MODE == $past(PWDATA[0]))
      else $error("split mode wrong");
   freq_top_a: assert property (wr_done && PADDR == 8'h04
      |=> TOP_FROM_COMPARE0 == ($past(PWDATA[2:0]) == 3'h1)) else $error("top source wrong");
   dir_set_a: assert property (wr_done && PADDR == 8'h14 && PWDATA[0] && PWDATA[3:2] != 2'h3 |=> COUNT_DOWN)
      else $error("direction not set");
   dir_clear_a: assert property (wr_done && PADDR == 8'h10 && PWDATA[0] |=> !COUNT_DOWN)
      else $error("direction not cleared");
   hard_reset_idle_a: assert property (HARD_RESET_PULSE |-> !COUNT_RUN && !LOCK_UPDATE && !COUNT_DOWN)
      else $error("hard reset while running or state kept");
endmodule : timer_control_sva
bind timer_control timer_control_sva i_sva (.REF_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
   .PREADY, .PSLVERR, .COUNT_RUN, .COUNT_TICK, .COUNT_DOWN, .TOP_FROM_COMPARE0, .SPLIT_MODE, .HARD_RESET_PULSE,
   .LOCK_UPDATE);

// *** tb/tb.sv ***
// Self-checking bench for the timer control block
`timescale 1ns/1ps
`include "timer_cfg.svh"
module tb;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} row_type;
   logic REF_CLK = 1'h0, NRST = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, STANDBY_SLEEP = 1'h0;
   logic COUNT_AT_TOP = 1'h0, COUNT_AT_BOTTOM = 1'h0, LENGTH_BUFFER_WRITE = 1'h0;
   logic EVENT_DIR_LOAD = 1'h0, EVENT_DIR = 1'h0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic [2:0] COMPARE_BUFFER_WRITE = 3'h0, WAVE_GEN = 3'h0, WAVE_PIN, WAVE_PIN_OE, WAVE_LOGIC;
   logic PREADY, PSLVERR, COUNT_RUN, COUNT_TICK, COUNT_DOWN, TOP_FROM_COMPARE0, SPLIT_MODE, UPDATE_LOAD;
   logic RESTART_PULSE, HARD_RESET_PULSE, OVERFLOW_PULSE, LOCK_UPDATE;
   int err_total = 0, comparisons = 0;
   int div[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
   // Address, write data, read-back, refusal
   row_type rows[12] = '{'{8'h00, 8'hFF, 8'h8F, 1'h0}, '{8'h00, 8'h00, 8'h00, 1'h0}, '{8'h04, 8'hF7, 8'h77, 1'h0},
      '{8'h08, 8'hFF, 8'h07, 1'h0}, '{8'h0C, 8'hFF, 8'h01, 1'h0}, '{8'h10, 8'hFF, 8'h00, 1'h0},
      '{8'h14, 8'h03, 8'h03, 1'h0}, '{8'h10, 8'h01, 8'h02, 1'h0}, '{8'h1C, 8'h0F, 8'h0F, 1'h0},
      '{8'h18, 8'h05, 8'h0A, 1'h0}, '{8'h02, 8'hFF, 8'h00, 1'h1}, '{8'hE0, 8'hFF, 8'h00, 1'h1}};
   // 200 MHz clock
   always #2.5 REF_CLK = ~REF_CLK;
   timer_control i_dut (.REF_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
      .STANDBY_SLEEP, .COUNT_AT_TOP, .COUNT_AT_BOTTOM, .LENGTH_BUFFER_WRITE, .COMPARE_BUFFER_WRITE, .EVENT_DIR_LOAD,
      .EVENT_DIR, .WAVE_GEN, .COUNT_RUN, .COUNT_TICK, .COUNT_DOWN, .TOP_FROM_COMPARE0, .SPLIT_MODE, .UPDATE_LOAD,
      .RESTART_PULSE, .HARD_RESET_PULSE, .OVERFLOW_PULSE, .LOCK_UPDATE, .WAVE_PIN, .WAVE_PIN_OE, .WAVE_LOGIC);
   // Comparisons of read data and of output levels
   task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_reg
   task automatic chk_pin(input string what, input logic [2:0] exp, input logic [2:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_pin
   // One APB transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd,
      output logic er);
      int n;
      n = 0;
      @(posedge REF_CLK);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {24'h0, d};
      @(posedge REF_CLK);
      PENABLE <= 1'h1;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (PREADY !== 1'h1 && n < 20);
      if (PREADY !== 1'h1) err_total++;
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'h1, a, d, rd, er);
   endtask : wr
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] q);
      logic [31:0] rd;
      logic er;
      apb(1'h0, a, 8'h00, rd, er);
      chk_reg(what, {24'h0, q}, rd);
   endtask : rchk
   // Counter position pulse; answer is seen in the cycle after it is taken
   task automatic pulse(input logic t, input logic b, output logic upd, output logic ovf);
      @(posedge REF_CLK);
      COUNT_AT_TOP <= t;
      COUNT_AT_BOTTOM <= b;
      @(posedge REF_CLK);
      COUNT_AT_TOP <= 1'h0;
      COUNT_AT_BOTTOM <= 1'h0;
      @(posedge REF_CLK);
      upd = UPDATE_LOAD;
      ovf = OVERFLOW_PULSE;
   endtask : pulse
   task automatic bufw(input logic len, input logic [2:0] cmp);
      @(posedge REF_CLK);
      LENGTH_BUFFER_WRITE <= len;
      COMPARE_BUFFER_WRITE <= cmp;
      @(posedge REF_CLK);
      LENGTH_BUFFER_WRITE <= 1'h0;
      COMPARE_BUFFER_WRITE <= 3'h0;
   endtask : bufw
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   // Main sequence
   initial begin
      logic [31:0] rd;
      logic er, u, o;
      int n;
      repeat (12) @(posedge REF_CLK);
      NRST <= 1'h1;
      for (int i = 0; i < 8; i++) rchk("reset value", 8'(4 * i), 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         apb(1'h0, rows[i].a, 8'h00, rd, er);
         chk_reg("readback", {24'h0, rows[i].q}, rd);
         chk_pin("slave error", rows[i].e, er);
      end
      $display("test registers done");
      // Run gating by enable and standby
      wr(8'h00, 8'h01);
      repeat (3) @(posedge REF_CLK);
      chk_pin("run", 3'h1, COUNT_RUN);
      STANDBY_SLEEP <= 1'h1;
      repeat (3) @(posedge REF_CLK);
      chk_pin("halt in standby", 3'h0, COUNT_RUN);
      wr(8'h00, 8'h81);
      repeat (3) @(posedge REF_CLK);
      chk_pin("run in standby", 3'h1, COUNT_RUN);
      STANDBY_SLEEP <= 1'h0;
      // Window of 1024 cycles holds a whole number of tick periods
      for (int c = 0; c < 8; c++) begin
         wr(8'h00, {4'h0, c[2:0], 1'h1});
         repeat (4) @(posedge REF_CLK);
         n = 0;
         repeat (1024) begin
            @(posedge REF_CLK);
            if (COUNT_TICK === 1'h1) n++;
         end
         chk_reg("tick count", 1024 / div[c], n);
      end
      $display("test run and prescaler done");
      // Direct output values while stopped, pad enables per mode
      wr(8'h00, 8'h00);
      wr(8'h08, 8'h05);
      @(posedge REF_CLK);
      chk_pin("direct value", 3'h5, WAVE_PIN);
      chk_pin("logic value", 3'h5, WAVE_LOGIC);
      // Pad enable follows the registered mode and enables, so it settles one cycle after them
      for (int m = 0; m < 8; m++) begin
         wr(8'h04, {4'h7, 1'h0, m[2:0]});
         repeat (2) @(posedge REF_CLK);
         chk_pin("pad enable", (m == 1 || m == 3 || m > 4) ? 3'h7 : 3'h0, WAVE_PIN_OE);
      end
      wr(8'h04, 8'h53);
      repeat (2) @(posedge REF_CLK);
      chk_pin("partial enable", 3'h5, WAVE_PIN_OE);
      WAVE_GEN <= 3'h2;
      wr(8'h00, 8'h01);
      wr(8'h08, 8'h07);
      repeat (2) @(posedge REF_CLK);
      chk_pin("running value", 3'h2, WAVE_PIN);
      wr(8'h00, 8'h00);
      $display("test waveform done");
      // Update and overflow moments for every mode code
      for (int m = 0; m < 8; m++) begin
         wr(8'h04, {5'h00, m[2:0]});
         wr(8'h10, 8'h03);
         pulse(1'h1, 1'h0, u, o);
         chk_pin("top update", m < 2, u);
         chk_pin("top overflow", m < 2 || m == 5 || m == 6, o);
         chk_pin("top direction", m > 4, COUNT_DOWN);
         pulse(1'h0, 1'h1, u, o);
         chk_pin("bottom update", m == 3 || m > 4, u);
         chk_pin("bottom overflow", m == 3 || m > 5, o);
      end
      // Buffer-valid flags, lock, commands
      wr(8'h04, 8'h00);
      bufw(1'h1, 3'h2);
      rchk("flags set", 8'h18, 8'h05);
      wr(8'h14, 8'h02);
      pulse(1'h1, 1'h0, u, o);
      chk_pin("locked update", 3'h0, u);
      rchk("flags kept", 8'h18, 8'h05);
      wr(8'h14, 8'h04);
      @(posedge REF_CLK);
      chk_pin("forced update", 3'h1, UPDATE_LOAD);
      rchk("flags cleared", 8'h18, 8'h00);
      wr(8'h14, 8'h08);
      @(posedge REF_CLK);
      chk_pin("restart", 3'h1, RESTART_PULSE);
      wr(8'h00, 8'h01);
      wr(8'h14, 8'h0C);
      @(posedge REF_CLK);
      chk_pin("reset ignored", 3'h0, HARD_RESET_PULSE);
      rchk("lock kept", 8'h14, 8'h02);
      wr(8'h00, 8'h00);
      wr(8'h14, 8'h0C);
      @(posedge REF_CLK);
      chk_pin("hard reset", 3'h1, HARD_RESET_PULSE);
      rchk("after reset", 8'h10, 8'h00);
      $display("test update and commands done");
      // Auto-lock with channel 0 enabled
      wr(8'h04, 8'h18);
      repeat (2) @(posedge REF_CLK);
      chk_pin("auto lock held", 3'h1, LOCK_UPDATE);
      bufw(1'h0, 3'h1);
      repeat (3) @(posedge REF_CLK);
      chk_pin("auto lock released", 3'h0, LOCK_UPDATE);
      pulse(1'h1, 1'h0, u, o);
      chk_pin("auto lock load", 3'h1, u);
      repeat (2) @(posedge REF_CLK);
      chk_pin("auto lock again", 3'h1, LOCK_UPDATE);
      rchk("auto lock field", 8'h04, 8'h18);
      // Direction loaded by an event action
      EVENT_DIR <= 1'h1;
      EVENT_DIR_LOAD <= 1'h1;
      @(posedge REF_CLK);
      EVENT_DIR_LOAD <= 1'h0;
      @(posedge REF_CLK);
      chk_pin("event direction", 3'h1, COUNT_DOWN);
      $display("test auto lock and direction done");
      // Reset in mid-run must drop the lock and the down direction left by the tests above
      NRST <= 1'h0;
      repeat (2) @(posedge REF_CLK);
      NRST <= 1'h1;
      @(posedge REF_CLK);
      chk_pin("reset lock and direction", 3'h0, {1'h0, LOCK_UPDATE, COUNT_DOWN});
      rchk("reset control B", 8'h04, 8'h00);
      $display("test mid-run reset done");
      complete_run();
   end
   // Watchdog sized well above the expected run of about 8600 cycles
   initial begin
      repeat (40000) @(posedge REF_CLK);
      err_total++;
      complete_run();
   end
endmodule : tb
